// [common/slp_pkg.sv]
// Purpose: constants, types and register map of the always-on sleep block
// Assumes: 16-bit registers at the printed offsets of a plain register port
// Notes:   one state struct carries every flip-flop of the block
package slp_pkg;

  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned EV_W   = 6;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CLAMP  = 13'h02c6;
  localparam logic [ADDR_W-1:0] ADDR_JDEN   = 13'h02d3;
  localparam logic [ADDR_W-1:0] ADDR_STAT   = 13'h1806;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 13'h1846;
  localparam logic [ADDR_W-1:0] ADDR_IRQCTL = 13'h1a80;
  localparam logic [ADDR_W-1:0] ADDR_RSTPUL = 13'h1ad0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CLAMP_SEL_LSB = 0;
  localparam int unsigned CLAMP_SEL_W   = 4;
  localparam int unsigned CLAMP_OVD_BIT = 4;
  localparam int unsigned JD_A_EN_BIT   = 0;
  localparam int unsigned JD_B_EN_BIT   = 1;
  localparam int unsigned EV_A_RISE     = 0;
  localparam int unsigned EV_A_FALL     = 1;
  localparam int unsigned EV_B_RISE     = 2;
  localparam int unsigned EV_B_FALL     = 3;
  localparam int unsigned EV_C_RISE     = 4;
  localparam int unsigned EV_C_FALL     = 5;
  localparam int unsigned LIVE_A_BIT    = 8;
  localparam int unsigned LIVE_B_BIT    = 9;
  localparam int unsigned LIVE_C_BIT    = 10;
  localparam int unsigned IRQ_GMASK_BIT = 0;
  localparam int unsigned IRQ_POLARITY_BIT   = 1;
  localparam int unsigned IRQ_OD_BIT    = 2;
  localparam int unsigned RST_PD_BIT    = 0;
  localparam int unsigned RST_PU_BIT    = 1;

  // ----------------------------------------------------------------
  // clamp logic selections
  // ----------------------------------------------------------------
  localparam logic [3:0] CLAMP_OFF  = 4'h0;
  localparam logic [3:0] CLAMP_A    = 4'h1;
  localparam logic [3:0] CLAMP_B    = 4'h2;
  localparam logic [3:0] CLAMP_AND  = 4'h3;
  localparam logic [3:0] CLAMP_OR   = 4'h4;
  localparam logic [3:0] CLAMP_NA   = 4'h5;
  localparam logic [3:0] CLAMP_NB   = 4'h6;
  localparam logic [3:0] CLAMP_NAND = 4'h7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]      CLAMP_RST  = 5'h00;
  localparam logic [1:0]      JDEN_RST   = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST   = 6'h3f;
  localparam logic [2:0]      IRQCTL_RST = 3'h0;
  localparam logic [1:0]      RSTPUL_RST = 2'h2;

  typedef enum logic [0:0] {SLP_ASLEEP, SLP_AWAKE} slp_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } slp_req_t;

  typedef struct packed {
    logic o;
    logic oe;
  } slp_pin_t;

  typedef struct packed {
    slp_mode_t         mode;
    logic              sup_s1;
    logic              sup_s2;
    logic              ldo_s1;
    logic              ldo_s2;
    logic              ja_s1;
    logic              ja_s2;
    logic              jb_s1;
    logic              jb_s2;
    logic              jst_a;
    logic              jst_b;
    logic              clamp;
    logic [4:0]        clamp_ctl;
    logic [1:0]        jd_en;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   mask;
    logic [2:0]        irq_ctl;
    logic [1:0]        rst_pull;
    logic              irq_hold;
    slp_pin_t          irq_pin;
    logic [DATA_W-1:0] rdata;
    logic              core_in_en;
    logic              core_out_en;
    logic              keeper_en;
    logic              ldo_en;
  } slp_state_t;

  localparam slp_state_t STATE_RST = '{
    mode:      SLP_ASLEEP,
    clamp_ctl: CLAMP_RST,
    jd_en:     JDEN_RST,
    mask:      MASK_RST,
    irq_ctl:   IRQCTL_RST,
    rst_pull:  RSTPUL_RST,
    irq_pin:   '{o: 1'b1, oe: 1'b1},
    default:   '0
  };

endpackage

// [design/slp_aon.sv]
// Purpose: always-on sleep domain: jack sense, clamp status, events, irq pin
// Assumes: core supply flag, regulator enable and jack pins are asynchronous
// Notes:   register port is dead while asleep; reads return zero then
`timescale 1ns/1ps
`default_nettype none

module slp_aon
  import slp_pkg::*;
(
  input  wire logic              clk,              // 40 MHz clock
  input  wire logic              nrst,             // async reset, active low
  input  wire logic              core_supply_ok,   // core supply present
  input  wire logic              regulator_enable_pin, // host regulator enable
  input  wire logic              jack_sense_in_a,  // jack pin a
  input  wire logic              jack_sense_in_b,  // jack pin b
  input  wire slp_req_t          reg_req,          // register request
  output logic [DATA_W-1:0]      reg_rdata,        // read data, next cycle
  output logic                   irq_o,            // irq pin level
  output logic                   irq_oe,           // irq pin drive enable
  output logic                   core_regulator_en, // core regulator enable
  output logic                   jack_status_a,    // jack status a
  output logic                   jack_status_b,    // jack status b
  output logic                   mic_detect_clamp, // clamp status
  output logic                   asleep,           // sleep state
  output logic                   core_in_en,       // core inputs accepted
  output logic                   core_out_en,      // core outputs driven
  output logic                   keeper_en,        // core bus keepers on
  output logic                   rst_pin_pullup,   // reset pin pull-up
  output logic                   rst_pin_pulldown  // reset pin pull-down
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic clamp_fn(
    input logic [3:0] sel,
    input logic       ovd,
    input logic       a,
    input logic       b
  );
    logic r;
    r = 1'b0;
    case (sel)
      CLAMP_A:    r = a;
      CLAMP_B:    r = b;
      CLAMP_AND:  r = a & b;
      CLAMP_OR:   r = a | b;
      CLAMP_NA:   r = ~a;
      CLAMP_NB:   r = ~b;
      CLAMP_NAND: r = ~(a & b);
      default:    r = 1'b0;
    endcase
    // override forces the clamp on whatever the jack state
    return r | ovd;
  endfunction

  function automatic slp_pin_t irq_drive(
    input logic act,
    input logic pol_high,
    input logic open_drain
  );
    slp_pin_t p;
    p.o  = pol_high ? act : ~act;
    // open drain only pulls low, so release the pin for a high level
    p.oe = ~open_drain | ~p.o;
    return p;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  slp_state_t s_q;
  slp_state_t s_d;

  logic            live_a;
  logic            live_b;
  logic            live_c;
  logic            awake;
  logic            rd_hit;
  logic            wr_hit;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic            irq_req;
  logic            irq_act;

  always_comb
  begin
    s_d = s_q;

    // two-stage synchronisers on every asynchronous pin
    s_d.sup_s1 = core_supply_ok;
    s_d.sup_s2 = s_q.sup_s1;
    s_d.ldo_s1 = regulator_enable_pin;
    s_d.ldo_s2 = s_q.ldo_s1;
    s_d.ja_s1  = jack_sense_in_a;
    s_d.ja_s2  = s_q.ja_s1;
    s_d.jb_s1  = jack_sense_in_b;
    s_d.jb_s2  = s_q.jb_s1;

    // regulator enable pin stays live in sleep
    s_d.ldo_en = s_q.ldo_s2;

    // jack status and clamp run in every mode
    live_a = s_q.jd_en[JD_A_EN_BIT] & s_q.ja_s2;
    live_b = s_q.jd_en[JD_B_EN_BIT] & s_q.jb_s2;
    live_c = clamp_fn(s_q.clamp_ctl[CLAMP_SEL_LSB +: CLAMP_SEL_W],
                      s_q.clamp_ctl[CLAMP_OVD_BIT], live_a, live_b);
    s_d.jst_a = live_a;
    s_d.jst_b = live_b;
    s_d.clamp = live_c;

    // edge events, asleep or awake
    ev_set = '0;
    ev_set[EV_A_RISE] = live_a & ~s_q.jst_a;
    ev_set[EV_A_FALL] = ~live_a & s_q.jst_a;
    ev_set[EV_B_RISE] = live_b & ~s_q.jst_b;
    ev_set[EV_B_FALL] = ~live_b & s_q.jst_b;
    ev_set[EV_C_RISE] = live_c & ~s_q.clamp;
    ev_set[EV_C_FALL] = ~live_c & s_q.clamp;

    // register port only while awake
    awake  = (s_q.mode == SLP_AWAKE);
    rd_hit = awake & reg_req.rd;
    wr_hit = awake & reg_req.wr;

    ev_clr = '0;
    if (rd_hit && (reg_req.addr == ADDR_STAT))
    begin
      ev_clr = '1;
    end
    // a new edge wins over a read-clear in the same cycle
    s_d.ev = (s_q.ev & ~ev_clr) | ev_set;

    if (wr_hit)
    begin
      case (reg_req.addr)
        ADDR_CLAMP:  s_d.clamp_ctl = reg_req.wdata[4:0];
        ADDR_JDEN:   s_d.jd_en     = reg_req.wdata[1:0];
        ADDR_MASK:   s_d.mask      = reg_req.wdata[EV_W-1:0];
        ADDR_IRQCTL: s_d.irq_ctl   = reg_req.wdata[2:0];
        ADDR_RSTPUL: s_d.rst_pull  = reg_req.wdata[1:0];
        default:     s_d.rst_pull  = s_q.rst_pull;
      endcase
    end

    // read data stand for one cycle only; zero when asleep or unmapped
    s_d.rdata = '0;
    if (rd_hit)
    begin
      case (reg_req.addr)
        ADDR_CLAMP:  s_d.rdata[4:0]      = s_q.clamp_ctl;
        ADDR_JDEN:   s_d.rdata[1:0]      = s_q.jd_en;
        ADDR_STAT:
        begin
          s_d.rdata[EV_W-1:0]  = s_q.ev;
          s_d.rdata[LIVE_A_BIT] = s_q.jst_a;
          s_d.rdata[LIVE_B_BIT] = s_q.jst_b;
          s_d.rdata[LIVE_C_BIT] = s_q.clamp;
        end
        ADDR_MASK:   s_d.rdata[EV_W-1:0] = s_q.mask;
        ADDR_IRQCTL: s_d.rdata[2:0]      = s_q.irq_ctl;
        ADDR_RSTPUL: s_d.rdata[1:0]      = s_q.rst_pull;
        default:     s_d.rdata           = '0;
      endcase
    end

    // power mode; only the supply flag moves it, never a jack edge
    case (s_q.mode)
      SLP_AWAKE:
      begin
        if (!s_q.sup_s2)
        begin
          s_d.mode = SLP_ASLEEP;
        end
      end
      SLP_ASLEEP:
      begin
        if (s_q.sup_s2)
        begin
          // supply returns once the host raised the regulator enable
          s_d.mode     = SLP_AWAKE;
          s_d.irq_hold = 1'b0;
        end
      end
      default:
      begin
        s_d.mode = SLP_ASLEEP;
      end
    endcase

    // only jack-derived flags exist, so sleep irq has no other cause
    irq_req = (|(s_q.ev & ~s_q.mask)) & ~s_q.irq_ctl[IRQ_GMASK_BIT];
    if ((s_q.mode == SLP_ASLEEP) && (s_d.mode == SLP_ASLEEP) && irq_req)
    begin
      s_d.irq_hold = 1'b1;
    end
    irq_act = irq_req | s_q.irq_hold;
    s_d.irq_pin = irq_drive(irq_act, s_q.irq_ctl[IRQ_POLARITY_BIT],
                            s_q.irq_ctl[IRQ_OD_BIT]);

    // core pins gated off while asleep
    s_d.core_in_en  = (s_d.mode == SLP_AWAKE);
    s_d.core_out_en = (s_d.mode == SLP_AWAKE);
    s_d.keeper_en   = (s_d.mode == SLP_AWAKE);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // only nrst resets; sleep transitions leave settings and flags intact
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata         = s_q.rdata;
  assign irq_o             = s_q.irq_pin.o;
  assign irq_oe            = s_q.irq_pin.oe;
  assign core_regulator_en = s_q.ldo_en;
  assign jack_status_a     = s_q.jst_a;
  assign jack_status_b     = s_q.jst_b;
  assign mic_detect_clamp  = s_q.clamp;
  assign asleep            = (s_q.mode == SLP_ASLEEP);
  assign core_in_en        = s_q.core_in_en;
  assign core_out_en       = s_q.core_out_en;
  assign keeper_en         = s_q.keeper_en;
  assign rst_pin_pullup    = s_q.rst_pull[RST_PU_BIT];
  assign rst_pin_pulldown  = s_q.rst_pull[RST_PD_BIT];

endmodule

`default_nettype wire

// [verification/slp_aon_asserts.sv]
// Purpose: port checks of the always-on sleep block
// Assumes: one clock domain, nrst async active low
// Notes:   a register write in the cycle sleep begins still lands
`timescale 1ns/1ps
`default_nettype none
module slp_aon_asserts
  import slp_pkg::*;
(
  input wire logic              clk,              // clock
  input wire logic              nrst,             // reset
  input wire logic              core_supply_ok,   // supply
  input wire logic              jack_sense_in_a,  // pin a
  input wire logic              jack_sense_in_b,  // pin b
  input wire slp_req_t          reg_req,          // request
  input wire logic [DATA_W-1:0] reg_rdata,        // read data
  input wire logic              irq_o,            // irq level
  input wire logic              irq_oe,           // irq enable
  input wire logic              jack_status_a,    // status a
  input wire logic              jack_status_b,    // status b
  input wire logic              mic_detect_clamp, // clamp
  input wire logic              asleep,           // sleep
  input wire logic              core_in_en,       // core in
  input wire logic              core_out_en,      // core out
  input wire logic              keeper_en         // keepers
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_sleep_on_loss: assert property (!core_supply_ok [*3] |=> asleep)
    else $error("not asleep after supply loss");
  a_wake_on_supply: assert property (core_supply_ok [*3] |=> !asleep)
    else $error("not awake after supply return");
  a_core_pins_off: assert property (
    asleep |-> !(core_in_en || core_out_en || keeper_en))
    else $error("core pins active in sleep");
  a_port_refused: assert property (
    !(reg_req.rd && !asleep) |=> reg_rdata == '0)
    else $error("read data outside a served read");
  a_irq_held: assert property (
    asleep && $past(asleep) && $changed({irq_o, irq_oe})
    |=> $stable({irq_o, irq_oe}) || !asleep)
    else $error("irq moved twice in sleep");
  a_irq_jack_only: assert property (
    asleep && $past(asleep) && $changed({irq_o, irq_oe})
    |-> $past({jack_status_a, jack_status_b, mic_detect_clamp})
        != $past({jack_status_a, jack_status_b, mic_detect_clamp}, 2))
    else $error("irq moved in sleep without jack change");
  a_jack_a_rise: assert property ($rose(jack_status_a) |-> $past(jack_sense_in_a, 3))
    else $error("status a rose without pin a");
  a_jack_b_rise: assert property ($rose(jack_status_b) |-> $past(jack_sense_in_b, 3))
    else $error("status b rose without pin b");
endmodule
bind slp_aon slp_aon_asserts slp_aon_asserts_inst (
  .clk(clk), .nrst(nrst), .core_supply_ok(core_supply_ok),
  .jack_sense_in_a(jack_sense_in_a), .jack_sense_in_b(jack_sense_in_b),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_o(irq_o), .irq_oe(irq_oe),
  .jack_status_a(jack_status_a), .jack_status_b(jack_status_b),
  .mic_detect_clamp(mic_detect_clamp), .asleep(asleep),
  .core_in_en(core_in_en), .core_out_en(core_out_en), .keeper_en(keeper_en)
);
`default_nettype wire

// [verification/slp_aon_tb.sv]
// Purpose: self-checking bench of the always-on sleep block
// Assumes: 40 MHz clock, host model powers the core rail
// Notes:   irq is active low CMOS except in the drive-type check
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module slp_aon_tb;
  import slp_pkg::*;
  localparam logic [ADDR_W-1:0] ADR [6] = '{ADDR_CLAMP, ADDR_JDEN, ADDR_MASK,
    ADDR_IRQCTL, ADDR_RSTPUL, 13'h0123};
  localparam logic [DATA_W-1:0] RST [6] = '{16'h0, 16'h0, 16'h3f, 16'h0, 16'h2, 16'h0};
  localparam logic [DATA_W-1:0] WM  [6] = '{16'h1f, 16'h3, 16'h3f, 16'h7, 16'h3, 16'h0};
  // clamp truth per select, bit index {a,b}
  localparam logic [3:0]        TT  [8] = '{4'h0, 4'hc, 4'ha, 4'h8, 4'he, 4'h3, 4'h5, 4'h7};
  logic              clk, nrst, want_awake, wake_on_irq, ja, jb, regen, supply;
  logic              irq_o, irq_oe, reg_en, st_a, st_b, clampv, asleep, ci, co, ke, pu, pd;
  slp_req_t          req;
  logic [DATA_W-1:0] rdata;
  int                fails, samples_checked;
  slp_aon slp_aon_inst (.clk(clk), .nrst(nrst), .core_supply_ok(supply),
    .regulator_enable_pin(regen), .jack_sense_in_a(ja), .jack_sense_in_b(jb),
    .reg_req(req), .reg_rdata(rdata), .irq_o(irq_o), .irq_oe(irq_oe),
    .core_regulator_en(reg_en), .jack_status_a(st_a), .jack_status_b(st_b),
    .mic_detect_clamp(clampv), .asleep(asleep), .core_in_en(ci), .core_out_en(co),
    .keeper_en(ke), .rst_pin_pullup(pu), .rst_pin_pulldown(pd));
  slp_host_model slp_host_model_inst (.clk(clk), .nrst(nrst), .want_awake(want_awake),
    .wake_on_irq(wake_on_irq), .irq_o(irq_o), .irq_oe(irq_oe),
    .core_regulator_en(reg_en), .regulator_enable_pin(regen), .core_supply_ok(supply));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    // let the write settle before any compare that follows the call
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask
  task automatic pins(input logic a, input logic b);
    @(posedge clk);
    ja <= a;
    jb <= b;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic wait_mode(input logic s);
    for (int n = 0; n < 200 && asleep !== s; n++)
    begin
      @(posedge clk);
      #1;
    end
    `CHK("mode", s, asleep)
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #100000;
    fails++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {nrst, wake_on_irq, ja, jb} = 4'h0;
    want_awake = 1'b1;
    req = '0;
    fails = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    `CHK("reset outputs", 6'h3a, {asleep, irq_o, irq_oe, ci, pu, pd})
    nrst <= 1'b1;
    wait_mode(1'b0);
    foreach (ADR[i])
    begin
      rd(ADR[i], RST[i], "reset value");
      wr(ADR[i], 16'hffff);
      rd(ADR[i], WM[i], "written value");
      wr(ADR[i], RST[i]);
    end
    wr(ADDR_RSTPUL, 16'h0001);
    `CHK("reset pin pulls", 2'b01, {pu, pd})
    wr(ADDR_JDEN, 16'h0003);
    for (int m = 0; m < 9; m++)
      for (int p = 0; p < 4; p++)
      begin
        wr(ADDR_CLAMP, m == 8 ? 16'h0010 : 16'(m));
        pins(p[1], p[0]);
        `CHK("jack status", p[1:0], {st_a, st_b})
        `CHK("clamp", m == 8 ? 1'b1 : TT[m][p], clampv)
      end
    wr(ADDR_CLAMP, {12'h000, CLAMP_A});
    pins(1'b0, 1'b0);
    `CHK("masked irq", 1'b1, irq_o)
    rd(ADDR_STAT, 16'h003f, "all flags");
    rd(ADDR_STAT, 16'h0000, "flags cleared");
    $display("test regs and clamp done");
    wr(ADDR_MASK, 16'h0000);
    pins(1'b1, 1'b0);
    `CHK("irq on", 2'b01, {irq_o, irq_oe})
    rd(ADDR_STAT, 16'h0511, "rise flags");
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq cleared", 1'b1, irq_o)
    wr(ADDR_MASK, 16'h0022);
    pins(1'b0, 1'b0);
    `CHK("irq masked", 1'b1, irq_o)
    rd(ADDR_STAT, 16'h0022, "fall flags");
    wr(ADDR_IRQCTL, 16'h0004);
    @(posedge clk);
    #1;
    `CHK("open drain idle", 1'b0, irq_oe)
    wr(ADDR_IRQCTL, 16'h0002);
    @(posedge clk);
    #1;
    `CHK("active high idle", 2'b01, {irq_o, irq_oe})
    wr(ADDR_IRQCTL, 16'h0000);
    wr(ADDR_MASK, 16'h0000);
    $display("test events done");
    want_awake <= 1'b0;
    wait_mode(1'b1);
    `CHK("core pins", 4'h0, {ci, co, ke, reg_en})
    wr(ADDR_MASK, 16'h003f);
    rd(ADDR_MASK, 16'h0000, "read asleep");
    `CHK("irq quiet", 1'b1, irq_o)
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    `CHK("irq held asleep", 2'b01, {irq_o, asleep})
    wake_on_irq <= 1'b1;
    wait_mode(1'b0);
    `CHK("core pins awake", 4'hf, {ci, co, ke, reg_en})
    want_awake <= 1'b1;
    wake_on_irq <= 1'b0;
    rd(ADDR_MASK, 16'h0000, "kept mask");
    rd(ADDR_STAT, 16'h000c, "sleep flags");
    $display("test sleep done");
    end_of_test();
  end
endmodule
`default_nettype wire

// [verification/slp_host_model.sv]
// Purpose: host processor and core regulator beside the sleep block
// Assumes: irq line has a pull-up
// Notes:   core rail follows the regulator enable after RAMP+1 cycles
`timescale 1ns/1ps
`default_nettype none
module slp_host_model
  import slp_pkg::*;
#(
  parameter int RAMP = 6
)
(
  input  wire logic clk,                  // clock
  input  wire logic nrst,                 // reset
  input  wire logic want_awake,           // bench wants core power
  input  wire logic wake_on_irq,          // wake on a low irq line
  input  wire logic irq_o,                // irq level
  input  wire logic irq_oe,               // irq drive enable
  input  wire logic core_regulator_en,    // regulator enable
  output logic      regulator_enable_pin, // enable pin
  output logic      core_supply_ok        // core rail present
);
  logic       irq_line;
  logic [7:0] ramp_q;
  // undriven line floats up through the pull-up
  assign irq_line = irq_oe ? irq_o : 1'b1;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      regulator_enable_pin <= 1'b0;
      core_supply_ok <= 1'b0;
      ramp_q <= 8'h00;
    end
    else
    begin
      regulator_enable_pin <= want_awake || (wake_on_irq && !irq_line);
      ramp_q <= (core_supply_ok == core_regulator_en) ? 8'h00 : ramp_q + 8'h01;
      if (ramp_q == 8'(RAMP))
        core_supply_ok <= core_regulator_en;
    end
endmodule
`default_nettype wire
